// >>> src/imsc_controller.sv
/*
  Byte-level two-wire serial controller, master and slave, with its
  configuration, control/status and data registers on the I/O port bus.
  Assumes I/O strobes and pin inputs are synchronous to clk_sys, and that the
  GPIO block supplies its own pin values for the low two bits of ports 1 and 2.
*/
//
// Functional notes
// - position bit selects port 1 or port 2
// - serial clock on bit 0, data on bit 1
// - enabled pins forced to open drain
// - disabled gives pins back to GPIO
// - registers at 0x28 and 0x29, split data
// - master start sends data register as address
// - arbitration loss clears master, flags, interrupts
// - loss interrupt waits for external transaction end
// - proceed sets busy; busy blocks control writes
// - busy clear after interrupt until proceed written
// - ack bit drives ack; loaded inverted after transmit
// - address flag set first slave byte, cleared on proceed
// - arbitration flag meaningful after master attempt
// - restart starts at once; hardware clears restart bit
// - stop flag set on stop as receiving slave
// - no stop flag when firmware ends by nack
// - interrupt per byte, on stop as receiving slave, on loss
// - controller handles lines at bit level
`timescale 1ns/1ps
module imsc_controller #(
  parameter int HALF_CYC = imsc_pkg::HALF_CYC,
  parameter int FIFO_DEPTH = imsc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire imsc_pkg::imsc_io_req_type io_req,
  output logic [7:0] io_rdata,
  output logic irq,
  input wire logic [1:0] p1_pin_i,
  input wire logic [1:0] p2_pin_i,
  input wire imsc_pkg::imsc_pins_type gpio_p1,
  input wire imsc_pkg::imsc_pins_type gpio_p2,
  output imsc_pkg::imsc_pins_type p1_pin,
  output imsc_pkg::imsc_pins_type p2_pin
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    imsc_pkg::imsc_state_type st;
    logic master;
    logic last_rx;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic scl_low;
    logic sda_low;
    logic gen_run;
    logic scl_q;
    logic sda_q;
    imsc_pkg::imsc_ctrl_type ctl;
    logic [7:0] cfg;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rd_full;
    logic irq;
    logic [7:0] rdo;
    imsc_pkg::imsc_pins_type p1;
    imsc_pkg::imsc_pins_type p2;
  } imsc_ctl_state_type;

  imsc_ctl_state_type s_r;
  imsc_ctl_state_type s_nxt;

  logic scl_in;
  logic sda_in;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic hold;
  logic tick;
  logic push;
  logic pop;
  logic fifo_ir;
  logic fifo_ov;
  logic [7:0] fifo_od;
  logic sel_p2;
  imsc_pkg::imsc_pins_type bus_pins;

  assign io_rdata = s_r.rdo;
  assign irq = s_r.irq;
  assign p1_pin = s_r.p1;
  assign p2_pin = s_r.p2;

  // ----------------------------------------
  // Line sensing
  // ----------------------------------------
  assign sel_p2 = s_r.cfg[imsc_pkg::CFG_POS];
  assign scl_in = sel_p2 ? p2_pin_i[imsc_pkg::SCL_BIT] : p1_pin_i[imsc_pkg::SCL_BIT];
  assign sda_in = sel_p2 ? p2_pin_i[imsc_pkg::SDA_BIT] : p1_pin_i[imsc_pkg::SDA_BIT];
  assign scl_rise = scl_in & ~s_r.scl_q;
  assign scl_fall = ~scl_in & s_r.scl_q;
  assign start_c = scl_in & s_r.scl_q & s_r.sda_q & ~sda_in;
  assign stop_c = scl_in & s_r.scl_q & ~s_r.sda_q & sda_in;
  assign hold = (s_r.st == imsc_pkg::ST_WAIT) || (s_r.st == imsc_pkg::ST_RDONE);

  // Only drive low, never high: open-drain on the two bus pins
  assign bus_pins.o = 2'b00;
  assign bus_pins.oe = {s_r.sda_low, s_r.scl_low};

  // ----------------------------------------
  // Clock divider and receive buffer
  // ----------------------------------------
  imsc_half_div #(
    .HALF(HALF_CYC)
  ) u_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clr(scl_rise | scl_fall | ~s_r.master),
    .tick(tick)
  );

  imsc_fifo #(
    .WIDTH(imsc_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(fifo_ir),
    .in_data(s_r.sh),
    .out_valid(fifo_ov),
    .out_ready(pop),
    .out_data(fifo_od)
  );

  // ----------------------------------------
  // Next operation after firmware proceeds
  // ----------------------------------------
  function automatic imsc_ctl_state_type next_op(input imsc_ctl_state_type s);
    imsc_ctl_state_type n;
    n = s;
    n.bitcnt = 4'h0;
    if (s.master && s.ctl.arb) begin
      n.st = imsc_pkg::ST_RESTART;
      n.sda_low = 1'b0;
      n.gen_run = 1'b0;
    end else if (s.master && !s.ctl.mstr) begin
      n.st = imsc_pkg::ST_STOP;
      n.sda_low = 1'b1;
      n.gen_run = 1'b0;
    end else if (!s.master && !s.ctl.ack) begin
      n.st = imsc_pkg::ST_IDLE;
      n.sda_low = 1'b0;
      n.scl_low = 1'b0;
      n.ctl.busy = 1'b0;
    end else begin
      n.st = imsc_pkg::ST_XFER;
      n.last_rx = ~s.ctl.xmit;
      n.sh = s.wdata;
      n.sda_low = s.ctl.xmit & ~s.wdata[7];
      if (!s.master) begin
        n.scl_low = 1'b0;
      end
    end
    return n;
  endfunction

  // ----------------------------------------
  // Registers and bit engine
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    push = 1'b0;
    pop = 1'b0;
    s_nxt.irq = 1'b0;
    s_nxt.scl_q = scl_in;
    s_nxt.sda_q = sda_in;

    // Register writes; control ignored while busy
    if (io_req.wr) begin
      case (io_req.addr)
        imsc_pkg::ADDR_CFG: begin
          s_nxt.cfg = io_req.wdata & imsc_pkg::CFG_WMASK;
        end
        imsc_pkg::ADDR_CTRL: begin
          if (!s_r.ctl.busy) begin
            s_nxt.ctl = imsc_pkg::imsc_ctrl_type'(io_req.wdata);
            if (s_nxt.ctl.busy) begin
              s_nxt.ctl.addr = 1'b0;
            end
          end
        end
        imsc_pkg::ADDR_DATA: begin
          s_nxt.wdata = io_req.wdata;
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered one cycle later
    if (io_req.rd) begin
      case (io_req.addr)
        imsc_pkg::ADDR_CFG: s_nxt.rdo = s_r.cfg;
        imsc_pkg::ADDR_CTRL: s_nxt.rdo = s_r.ctl;
        imsc_pkg::ADDR_DATA: begin
          s_nxt.rdo = s_r.rdata;
          s_nxt.rd_full = 1'b0;
        end
        default: s_nxt.rdo = 8'h00;
      endcase
    end

    // Move the oldest received byte into the read-side data register
    if (fifo_ov && !s_nxt.rd_full) begin
      pop = 1'b1;
      s_nxt.rdata = fifo_od;
      s_nxt.rd_full = 1'b1;
    end

    // Master clock generator, following a stretched or slower clock
    if (tick && s_r.master) begin
      if (s_r.scl_low && !hold) begin
        s_nxt.scl_low = 1'b0;
      end else if (!s_r.scl_low && scl_in && s_r.gen_run) begin
        s_nxt.scl_low = 1'b1;
      end
    end

    case (s_r.st)
      imsc_pkg::ST_IDLE: begin
        if (start_c) begin
          s_nxt.st = imsc_pkg::ST_XFER;
          s_nxt.master = 1'b0;
          s_nxt.last_rx = 1'b1;
          s_nxt.bitcnt = 4'h0;
          s_nxt.ctl.addr = 1'b1;
        end else if (s_r.ctl.busy && s_r.ctl.mstr) begin
          if (scl_in && sda_in) begin
            s_nxt.st = imsc_pkg::ST_MSTART;
            s_nxt.master = 1'b1;
            s_nxt.sda_low = 1'b1;
            s_nxt.gen_run = 1'b1;
          end
        end else if (s_r.ctl.busy) begin
          s_nxt.ctl.busy = 1'b0;
        end
      end
      imsc_pkg::ST_MSTART: begin
        if (scl_fall) begin
          s_nxt.st = imsc_pkg::ST_XFER;
          s_nxt.last_rx = 1'b0;
          s_nxt.bitcnt = 4'h0;
          s_nxt.sh = s_r.wdata;
          s_nxt.sda_low = ~s_r.wdata[7];
        end
      end
      imsc_pkg::ST_XFER: begin
        if (scl_rise) begin
          if (s_r.last_rx) begin
            s_nxt.sh = {s_r.sh[6:0], sda_in};
          end else if (s_r.bitcnt == 4'h8) begin
            s_nxt.ctl.ack = ~sda_in;
          end else if (s_r.master && !s_r.sda_low && !sda_in) begin
            s_nxt.st = imsc_pkg::ST_LOST;
            s_nxt.ctl.mstr = 1'b0;
            s_nxt.ctl.arb = 1'b1;
            s_nxt.master = 1'b0;
            s_nxt.gen_run = 1'b0;
            s_nxt.sda_low = 1'b0;
            s_nxt.scl_low = 1'b0;
          end
        end else if (scl_fall) begin
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          if (s_r.last_rx) begin
            if (s_r.bitcnt == 4'h7) begin
              s_nxt.st = imsc_pkg::ST_RDONE;
              s_nxt.scl_low = 1'b1;
            end
          end else if (s_r.bitcnt == 4'h7) begin
            s_nxt.sda_low = 1'b0;
          end else if (s_r.bitcnt == 4'h8) begin
            s_nxt.st = imsc_pkg::ST_WAIT;
            s_nxt.scl_low = 1'b1;
            s_nxt.irq = 1'b1;
            s_nxt.ctl.busy = 1'b0;
          end else begin
            s_nxt.sh = {s_r.sh[6:0], 1'b0};
            s_nxt.sda_low = ~s_r.sh[6];
          end
        end
      end
      imsc_pkg::ST_RDONE: begin
        if (fifo_ir) begin
          push = 1'b1;
          s_nxt.st = imsc_pkg::ST_WAIT;
          s_nxt.irq = 1'b1;
          s_nxt.ctl.busy = 1'b0;
        end
      end
      imsc_pkg::ST_WAIT: begin
        if (s_r.ctl.busy && s_r.last_rx) begin
          s_nxt.st = imsc_pkg::ST_ACK;
          s_nxt.sda_low = s_r.ctl.ack;
          if (!s_r.master) begin
            s_nxt.scl_low = 1'b0;
          end
        end else if (s_r.ctl.busy) begin
          s_nxt = next_op(s_nxt);
        end
      end
      imsc_pkg::ST_ACK: begin
        if (scl_fall) begin
          s_nxt.sda_low = 1'b0;
          s_nxt = next_op(s_nxt);
        end
      end
      imsc_pkg::ST_STOP: begin
        if (tick && !s_r.scl_low && scl_in) begin
          s_nxt.st = imsc_pkg::ST_IDLE;
          s_nxt.sda_low = 1'b0;
          s_nxt.master = 1'b0;
          s_nxt.ctl.busy = 1'b0;
        end
      end
      imsc_pkg::ST_RESTART: begin
        if (tick && !s_r.scl_low && scl_in) begin
          s_nxt.st = imsc_pkg::ST_MSTART;
          s_nxt.sda_low = 1'b1;
          s_nxt.gen_run = 1'b1;
          s_nxt.ctl.arb = 1'b0;
        end
      end
      imsc_pkg::ST_LOST: begin
        if (stop_c) begin
          s_nxt.st = imsc_pkg::ST_IDLE;
          s_nxt.irq = 1'b1;
          s_nxt.ctl.busy = 1'b0;
        end
      end
      default: begin
        s_nxt.st = imsc_pkg::ST_IDLE;
      end
    endcase

    // Stop or repeated start from an external master while slave
    if (!s_r.master && s_r.st != imsc_pkg::ST_IDLE && s_r.st != imsc_pkg::ST_LOST) begin
      if (stop_c) begin
        s_nxt.st = imsc_pkg::ST_IDLE;
        s_nxt.sda_low = 1'b0;
        s_nxt.scl_low = 1'b0;
        s_nxt.ctl.busy = 1'b0;
        if (s_r.last_rx) begin
          s_nxt.ctl.rstop = 1'b1;
          s_nxt.irq = 1'b1;
        end
      end else if (start_c) begin
        s_nxt.st = imsc_pkg::ST_XFER;
        s_nxt.last_rx = 1'b1;
        s_nxt.bitcnt = 4'h0;
        s_nxt.sda_low = 1'b0;
        s_nxt.ctl.addr = 1'b1;
      end
    end

    if (!s_r.ctl.en) begin
      s_nxt.st = imsc_pkg::ST_IDLE;
      s_nxt.master = 1'b0;
      s_nxt.gen_run = 1'b0;
      s_nxt.sda_low = 1'b0;
      s_nxt.scl_low = 1'b0;
    end

    // Pin routing: selected port carries the bus, the other stays GPIO
    s_nxt.p1 = (s_r.ctl.en && !sel_p2) ? bus_pins : gpio_p1;
    s_nxt.p2 = (s_r.ctl.en && sel_p2) ? bus_pins : gpio_p2;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.cfg <= imsc_pkg::CFG_RST;
      s_r.ctl <= imsc_pkg::imsc_ctrl_type'(imsc_pkg::CTRL_RST);
      s_r.wdata <= imsc_pkg::DATA_RST;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// >>> src/imsc_fifo.sv
/*
  Parameterised valid/ready FIFO for received bytes.
  Assumes one clock; DEPTH need not be a power of two.
*/
`timescale 1ns/1ps
module imsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } imsc_fifo_state_type;

  imsc_fifo_state_type s_r;
  imsc_fifo_state_type s_nxt;
  logic wr;
  logic rd;

  assign in_ready = (s_r.cnt != CW'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;

  always_comb begin
    s_nxt = s_r;
    if (wr) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (rd) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    if (wr && !rd) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (rd && !wr) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// >>> src/imsc_half_div.sv
/*
  Half-period divider for the generated serial clock.
  Assumes clr is asserted on every serial clock edge so each half restarts.
*/
`timescale 1ns/1ps
module imsc_half_div #(
  parameter int HALF = 50
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clr,
  output logic tick
);
  localparam int CW = $clog2(HALF + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } imsc_div_state_type;

  imsc_div_state_type s_r;
  imsc_div_state_type s_nxt;

  assign tick = s_r.tick;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (clr) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == CW'(HALF - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// >>> src/imsc_pkg.sv
/*
  Shared constants and carrier types for the two-wire serial controller.
  Assumes the core runs on clk_sys at 10 MHz with an 8-bit I/O port bus.
*/
package imsc_pkg;
  // ----------------------------------------
  // I/O addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h09;
  localparam logic [7:0] ADDR_CTRL = 8'h28;
  localparam logic [7:0] ADDR_DATA = 8'h29;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CFG_POS = 7;
  localparam logic [7:0] CFG_WMASK = 8'hF3;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int SCL_BIT = 0;
  localparam int SDA_BIT = 1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int HALF_CYC = (SCL_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Buffering
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } imsc_io_req_type;

  typedef struct packed {
    logic [1:0] o;
    logic [1:0] oe;
  } imsc_pins_type;

  // Bit order equals the control/status register layout, bit 7 first
  typedef struct packed {
    logic mstr;
    logic busy;
    logic xmit;
    logic ack;
    logic addr;
    logic arb;
    logic rstop;
    logic en;
  } imsc_ctrl_type;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_MSTART,
    ST_XFER,
    ST_RDONE,
    ST_WAIT,
    ST_ACK,
    ST_STOP,
    ST_RESTART,
    ST_LOST
  } imsc_state_type;
endpackage

// >>> test/imsc_bus_partner.sv
/*
  Behavioural two-wire slave on the far side of the bus.
  Assumes pulled-up wires sampled on clk_sys; answers reads with RD_BYTE.
*/
`timescale 1ns/1ps
module imsc_bus_partner #(
  parameter logic [6:0] SLV_ADDR = 7'h50,
  parameter logic [7:0] RD_BYTE = 8'h3C
) (
  input wire logic clk_sys,
  input wire logic scl,
  input wire logic sda,
  output logic sda_low,
  output logic [7:0] last_byte,
  output logic [3:0] stop_cnt
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic first = 1'b0;
  logic sel = 1'b0;
  logic rd_mode = 1'b0;
  logic [3:0] bit_cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'hFF;
  initial begin
    sda_low = 1'b0;
    last_byte = 8'h00;
    stop_cnt = 4'h0;
  end
  always @(posedge clk_sys) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      first <= 1'b1;
      bit_cnt <= 4'h0;
      sel <= 1'b0;
      rd_mode <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      stop_cnt <= stop_cnt + 4'h1;
      sel <= 1'b0;
      sda_low <= 1'b0;
    end else if (scl && !scl_q) begin
      sh <= (bit_cnt < 4'h8) ? {sh[6:0], sda} : sh;
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt == 4'h8 && sda && rd_mode) begin
        sel <= 1'b0;
      end
    end else if (!scl && scl_q) begin
      if (bit_cnt == 4'h8) begin
        last_byte <= sh;
        first <= 1'b0;
        if (first) begin
          sel <= sh[7:1] == SLV_ADDR;
          rd_mode <= sh[0];
          tx <= RD_BYTE;
          sda_low <= sh[7:1] == SLV_ADDR;
        end else begin
          sda_low <= sel && !rd_mode;
        end
      end else if (sel && rd_mode) begin
        sda_low <= !tx[7];
        tx <= {tx[6:0], 1'b1};
      end else begin
        sda_low <= 1'b0;
      end
    end
  end
endmodule

// >>> test/imsc_controller_properties.sv
/*
  Checker on the controller's top ports, bound into every instance.
  Assumes one clock clk_sys and asynchronous active-low rst_b.
*/
`timescale 1ns/1ps
module imsc_controller_checker #(
  parameter int HALF_CYC = 50,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire imsc_pkg::imsc_io_req_type io_req,
  input wire logic [7:0] io_rdata,
  input wire logic irq,
  input wire logic [1:0] p1_pin_i,
  input wire logic [1:0] p2_pin_i,
  input wire imsc_pkg::imsc_pins_type gpio_p1,
  input wire imsc_pkg::imsc_pins_type gpio_p2,
  input wire imsc_pkg::imsc_pins_type p1_pin,
  input wire imsc_pkg::imsc_pins_type p2_pin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ------------
  // Shadow state
  // ------------
  logic pos_r;
  logic pos_d_r;
  logic up_r;
  logic irq_seen_r;
  logic [15:0] hi_cnt_r;
  imsc_pkg::imsc_pins_type sel_q_r;
  imsc_pkg::imsc_pins_type uns_q_r;
  imsc_pkg::imsc_pins_type sel_pin;
  imsc_pkg::imsc_pins_type uns_pin;
  logic drv;
  logic wr_ctrl;
  logic rd_ctrl;
  logic rd_cfg;
  assign drv = (p1_pin.oe[0] & ~p1_pin.o[0]) | (p2_pin.oe[0] & ~p2_pin.o[0]);
  assign wr_ctrl = io_req.wr && io_req.addr == imsc_pkg::ADDR_CTRL;
  assign rd_ctrl = io_req.rd && io_req.addr == imsc_pkg::ADDR_CTRL;
  assign rd_cfg = io_req.rd && io_req.addr == imsc_pkg::ADDR_CFG;
  assign sel_pin = pos_d_r ? p2_pin : p1_pin;
  assign uns_pin = pos_d_r ? p1_pin : p2_pin;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pos_r <= 1'b0;
      pos_d_r <= 1'b0;
      up_r <= 1'b0;
      irq_seen_r <= 1'b0;
      hi_cnt_r <= 16'h0000;
      sel_q_r <= '0;
      uns_q_r <= '0;
    end else begin
      if (io_req.wr && io_req.addr == imsc_pkg::ADDR_CFG) begin
        pos_r <= io_req.wdata[imsc_pkg::CFG_POS];
      end
      pos_d_r <= pos_r;
      up_r <= 1'b1;
      sel_q_r <= pos_r ? gpio_p2 : gpio_p1;
      uns_q_r <= pos_r ? gpio_p1 : gpio_p2;
      if (irq) begin
        irq_seen_r <= 1'b1;
      end else if (wr_ctrl && io_req.wdata[6]) begin
        irq_seen_r <= 1'b0;
      end
      if (drv) begin
        hi_cnt_r <= 16'h0000;
      end else if (hi_cnt_r != 16'hFFFF) begin
        hi_cnt_r <= hi_cnt_r + 16'h0001;
      end
    end
  end
  // ----------
  // Assertions
  // ----------
  irq_one_cycle_a: assert property (irq |=> !irq)
    else $error("irq wider than one cycle");
  rdata_hold_a: assert property (!io_req.rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (io_req.rd && !(io_req.addr inside {8'h09, 8'h28, 8'h29})
    |=> io_rdata == 8'h00) else $error("unmapped read not zero");
  cfg_read_mask_a: assert property (io_req.wr && io_req.addr == 8'h09 ##2 rd_cfg
    |=> io_rdata == ($past(io_req.wdata, 3) & 8'hF3)) else $error("config readback wrong");
  unsel_port_gpio_a: assert property (up_r |-> uns_pin == uns_q_r)
    else $error("unselected port not given to gpio");
  sel_open_drain_a: assert property (sel_pin != sel_q_r |-> (sel_pin.o & sel_pin.oe) == 2'b00)
    else $error("bus pin driven high");
  busy_on_write_a: assert property (wr_ctrl && io_req.wdata[6] && io_req.wdata[0] ##2 rd_ctrl
    |=> io_rdata[6]) else $error("busy not set by proceed");
  busy_free_irq_a: assert property (rd_ctrl && irq_seen_r |=> !io_rdata[6])
    else $error("busy set after interrupt");
  clk_high_min_a: assert property ($rose(drv) |-> hi_cnt_r >= HALF_CYC - 1)
    else $error("serial clock high time too short");
  irq_c: cover property (irq);
  restart_c: cover property (wr_ctrl && io_req.wdata[2] && io_req.wdata[6]);
  port2_c: cover property (pos_d_r && p2_pin.oe == 2'b00);
endmodule

bind imsc_controller imsc_controller_checker #(.HALF_CYC(HALF_CYC), .FIFO_DEPTH(FIFO_DEPTH)) chk_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .io_req(io_req), .io_rdata(io_rdata), .irq(irq),
  .p1_pin_i(p1_pin_i), .p2_pin_i(p2_pin_i), .gpio_p1(gpio_p1), .gpio_p2(gpio_p2),
  .p1_pin(p1_pin), .p2_pin(p2_pin));

// >>> test/testbench.sv
/*
  Self-checking bench: firmware-style register accesses, slave partner on port 1.
  Assumes the checker is bound to the controller.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_sys;
  logic rst_b;
  imsc_pkg::imsc_io_req_type io_req;
  logic [7:0] io_rdata;
  logic irq;
  logic [1:0] p1_pin_i;
  logic [1:0] p2_pin_i;
  imsc_pkg::imsc_pins_type gpio_p1;
  imsc_pkg::imsc_pins_type gpio_p2;
  imsc_pkg::imsc_pins_type p1_pin;
  imsc_pkg::imsc_pins_type p2_pin;
  logic sda_low;
  logic [7:0] got_byte;
  logic [3:0] stop_cnt;
  logic [7:0] d;
  int error_cnt;
  int checks_done;
  int cyc;
  assign p1_pin_i[0] = !(p1_pin.oe[0] & !p1_pin.o[0]);
  assign p1_pin_i[1] = !(p1_pin.oe[1] & !p1_pin.o[1]) & !sda_low;
  assign p2_pin_i = ~(p2_pin.oe & ~p2_pin.o);
  imsc_controller #(.HALF_CYC(4), .FIFO_DEPTH(2)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .io_req(io_req), .io_rdata(io_rdata), .irq(irq),
    .p1_pin_i(p1_pin_i), .p2_pin_i(p2_pin_i), .gpio_p1(gpio_p1), .gpio_p2(gpio_p2),
    .p1_pin(p1_pin), .p2_pin(p2_pin));
  imsc_bus_partner partner (
    .clk_sys(clk_sys), .scl(p1_pin_i[0]), .sda(p1_pin_i[1]), .sda_low(sda_low),
    .last_byte(got_byte), .stop_cnt(stop_cnt));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    #1;
    io_req.addr = a;
    io_req.wdata = v;
    io_req.wr = 1'b1;
    @(posedge clk_sys);
    #1;
    io_req.wr = 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #1;
    io_req.addr = a;
    io_req.rd = 1'b1;
    @(posedge clk_sys);
    #1;
    io_req.rd = 1'b0;
    d = io_rdata;
    chk("register", e, d);
  endtask
  task wait_irq;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("irq", 8'h01, {7'h00, irq});
  endtask
  initial begin
    io_req = '0;
    gpio_p1 = 4'hF;
    gpio_p2 = 4'hD;
    rst_b = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    repeat (12) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    rdchk(8'h09, 8'h00);
    rdchk(8'h28, 8'h00);
    rdchk(8'h29, 8'h00);
    rdchk(8'h30, 8'h00);
    wr(8'h09, 8'hFF);
    rdchk(8'h09, 8'hF3);
    wr(8'h09, 8'h00);
    chk("p1 gpio", 8'h0F, {4'h0, p1_pin});
    wr(8'h28, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("p1 bus oe", 8'h00, {6'h00, p1_pin.oe});
    chk("p2 gpio", 8'h0D, {4'h0, p2_pin});
    wr(8'h09, 8'h80);
    repeat (2) @(posedge clk_sys);
    chk("p1 freed", 8'h0F, {4'h0, p1_pin});
    chk("p2 bus oe", 8'h00, {6'h00, p2_pin.oe});
    wr(8'h09, 8'h00);
    wr(8'h29, 8'hA0);
    wr(8'h28, 8'hE1);
    rdchk(8'h28, 8'hE1);
    wr(8'h28, 8'h00);
    rdchk(8'h28, 8'hE1);
    wait_irq();
    rdchk(8'h28, 8'hB1);
    chk("address", 8'hA0, got_byte);
    wr(8'h29, 8'h5A);
    wr(8'h28, 8'hE1);
    wait_irq();
    rdchk(8'h28, 8'hB1);
    chk("data out", 8'h5A, got_byte);
    wr(8'h29, 8'hC4);
    wr(8'h28, 8'hE5);
    wait_irq();
    rdchk(8'h28, 8'hA1);
    chk("restart addr", 8'hC4, got_byte);
    wr(8'h29, 8'hA1);
    wr(8'h28, 8'hE5);
    wait_irq();
    rdchk(8'h28, 8'hB1);
    wr(8'h28, 8'hC1);
    wait_irq();
    repeat (3) @(posedge clk_sys);
    rdchk(8'h29, 8'h3C);
    rdchk(8'h28, 8'h81);
    wr(8'h28, 8'h41);
    for (int i = 0; i < 500 && stop_cnt !== 4'h1; i++) begin
      @(posedge clk_sys);
    end
    chk("stops", 8'h01, {4'h0, stop_cnt});
    repeat (20) @(posedge clk_sys);
    rdchk(8'h28, 8'h01);
    wr(8'h28, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("p1 back", 8'h0F, {4'h0, p1_pin});
    stop_test();
  end
endmodule
